//--- qrs_controller.sv
// Purpose : Controller end: makes the input clocks, issues bursts, gathers reads.
// Assumes : K_HALF is even and at least 2 so every pin has setup and hold.
// Notes   : Writes pass an 8-entry FIFO of whole bursts; reads are taken one per K period.
`timescale 1ns/1ps
module qrs_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = qrs_pkg::FIFO_DEPTH
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int NW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [NW-1:0]           cnt;
    } qrs_fifo_state_type;

    qrs_fifo_state_type f_q;
    qrs_fifo_state_type f_d;
    logic               push;
    logic               pop;

    assign in_ready  = f_q.cnt != NW'(DEPTH);
    assign out_valid = f_q.cnt != '0;
    assign out_data  = f_q.mem[f_q.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        f_d = f_q;
        if (push) begin
            f_d.mem[f_q.wp] = in_data;
            f_d.wp = (f_q.wp == PW'(DEPTH - 1)) ? '0 : f_q.wp + PW'(1);
        end
        if (pop) begin
            f_d.rp = (f_q.rp == PW'(DEPTH - 1)) ? '0 : f_q.rp + PW'(1);
        end
        f_d.cnt = f_q.cnt + NW'(push) - NW'(pop);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end
endmodule

module qrs_controller #(
    parameter int DW          = qrs_pkg::DATA_WIDTH,
    parameter int AW          = qrs_pkg::ADDR_WIDTH,
    parameter int K_HALF      = qrs_pkg::K_HALF_CYCLES,
    parameter bit USE_OUT_CLK = 1'b1,
    parameter int FIFO_DEPTH  = qrs_pkg::FIFO_DEPTH
) (
    input  wire logic          clk,
    input  wire logic          rst_b,
    qrs_link_if.ctl            link,
    input  wire logic          dll_enable,
    input  wire logic          wr_valid,
    output logic               wr_ready,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data0,
    input  wire logic [DW-1:0] wr_data1,
    input  wire logic [DW/((DW == qrs_pkg::NARROW_WIDTH) ? qrs_pkg::LANE_NARROW : qrs_pkg::LANE_WIDE)-1:0] wr_sel0_n,
    input  wire logic [DW/((DW == qrs_pkg::NARROW_WIDTH) ? qrs_pkg::LANE_NARROW : qrs_pkg::LANE_WIDE)-1:0] wr_sel1_n,
    input  wire logic          rd_valid,
    output logic               rd_ready,
    input  wire logic [AW-1:0] rd_addr,
    output logic               rd_done,
    output logic      [DW-1:0] rd_data0,
    output logic      [DW-1:0] rd_data1
);
    localparam int SW = DW / ((DW == qrs_pkg::NARROW_WIDTH) ? qrs_pkg::LANE_NARROW
                                                            : qrs_pkg::LANE_WIDE);
    localparam int FW = AW + 2 * DW + 2 * SW;
    localparam int CW = $clog2(2 * K_HALF);

    typedef struct packed {
        logic          cq;
        logic          cqn;
        logic          oe;
        logic [DW-1:0] q;
    } qrs_ret_type;

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          kq;
        logic          rn;
        logic          wn;
        logic [AW-1:0] addr;
        logic [DW-1:0] d;
        logic [SW-1:0] sel_n;
        logic          dll_n;
        logic          wh_v;
        logic [AW-1:0] wh_a;
        logic [DW-1:0] wh_d;
        logic [SW-1:0] wh_s;
        qrs_ret_type   s1;
        qrs_ret_type   s2;
        logic [1:0]    echo_prev;
        logic          got0;
        logic [DW-1:0] rdata0;
        logic [DW-1:0] rdata1;
        logic          done;
    } qrs_ctl_state_type;

    qrs_ctl_state_type r_q;
    qrs_ctl_state_type r_d;
    logic              issue;
    logic              second;
    logic              f_valid;
    logic [FW-1:0]     f_data;
    logic [AW-1:0]     f_a;
    logic [DW-1:0]     f_d0;
    logic [DW-1:0]     f_d1;
    logic [SW-1:0]     f_s0;
    logic [SW-1:0]     f_s1;

    // ------------------------------------------------------------------
    // Write queue; the link drains one burst per K period
    // ------------------------------------------------------------------
    qrs_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   ({wr_addr, wr_data0, wr_data1, wr_sel0_n, wr_sel1_n}),
        .out_valid (f_valid),
        .out_ready (issue),
        .out_data  (f_data)
    );

    assign {f_a, f_d0, f_d1, f_s0, f_s1} = f_data;

    // Controls change a quarter period before K rises, write half before K complement
    assign issue    = r_q.cnt == CW'(K_HALF + K_HALF / 2 - 1);
    assign second   = r_q.cnt == CW'(K_HALF / 2 - 1);
    assign rd_ready = issue;

    always_comb begin
        r_d       = r_q;
        r_d.cnt   = (r_q.cnt == CW'(2 * K_HALF - 1)) ? '0 : r_q.cnt + CW'(1);
        r_d.kq    = r_d.cnt < CW'(K_HALF);
        r_d.dll_n = dll_enable;
        r_d.s1    = {link.echo_strobe_pos, link.echo_strobe_neg,
                     link.read_data_oe, link.read_data_out};
        r_d.s2    = r_q.s1;
        r_d.echo_prev = {r_q.s2.cq, r_q.s2.cqn};
        r_d.done  = 1'b0;

        if (issue) begin
            r_d.rn = ~rd_valid;
            if (rd_valid) begin
                r_d.addr = rd_addr;
            end
            r_d.wn   = ~f_valid;
            r_d.wh_v = f_valid;
            if (f_valid) begin
                r_d.d     = f_d0;
                r_d.sel_n = f_s0;
                r_d.wh_a  = f_a;
                r_d.wh_d  = f_d1;
                r_d.wh_s  = f_s1;
            end
        end

        if (second && r_q.wh_v) begin
            r_d.addr  = r_q.wh_a;
            r_d.d     = r_q.wh_d;
            r_d.sel_n = r_q.wh_s;
        end

        // Read words arrive with the echo strobes
        if (r_q.s2.cqn && !r_q.echo_prev[0] && r_q.s2.oe) begin
            r_d.rdata0 = r_q.s2.q;
            r_d.got0   = 1'b1;
        end
        if (r_q.s2.cq && !r_q.echo_prev[1] && r_q.got0) begin
            r_d.rdata1 = r_q.s2.q;
            r_d.got0   = 1'b0;
            r_d.done   = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            r_q       <= '0;
            // Count starts at the wrap so the first K high phase is full length
            r_q.cnt   <= CW'(2 * K_HALF - 1);
            r_q.rn    <= 1'b1;
            r_q.wn    <= 1'b1;
            r_q.sel_n <= '1;
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------
    assign link.k                = r_q.kq;
    assign link.k_n              = ~r_q.kq;
    assign link.c                = USE_OUT_CLK ? r_q.kq : 1'b1;
    assign link.c_n              = USE_OUT_CLK ? ~r_q.kq : 1'b1;
    assign link.read_n           = r_q.rn;
    assign link.write_n          = r_q.wn;
    assign link.addr             = r_q.addr;
    assign link.write_data_in    = r_q.d;
    assign link.byte_write_sel_n = r_q.sel_n;
    assign link.dll_off_n        = r_q.dll_n;
    assign rd_done               = r_q.done;
    assign rd_data0              = r_q.rdata0;
    assign rd_data1              = r_q.rdata1;
endmodule

//--- qrs_device.sv
// Purpose : Memory device end: two-word burst static RAM with split buses.
// Assumes : Every link pin is sampled by clk through two flip-flops.
// Notes   : Storage is flip-flops; depth is 2**(AW+1) words.
`timescale 1ns/1ps
module qrs_device #(
    parameter int DW    = qrs_pkg::DATA_WIDTH,
    parameter int AW    = qrs_pkg::ADDR_WIDTH,
    parameter int REF_W = qrs_pkg::REF_WIDTH
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    qrs_link_if.dev               link,
    input  wire logic [REF_W-1:0] impedance_ref_code,
    output logic      [REF_W-1:0] impedance_code,
    output logic                  impedance_cal,
    output logic                  lock_done,
    output logic                  dll_bypass
);

    // ------------------------------------------------------------------
    // Organisation
    // ------------------------------------------------------------------
    localparam int LANE  = (DW == qrs_pkg::NARROW_WIDTH) ? qrs_pkg::LANE_NARROW
                                                         : qrs_pkg::LANE_WIDE;
    localparam int SW    = DW / LANE;
    localparam int DEPTH = 2 ** (AW + 1);
    localparam int LCW   = $clog2(qrs_pkg::LOCK_CYCLES + 1);
    localparam int CCW   = $clog2(qrs_pkg::CAL_CYCLES + 1);

    typedef struct packed {
        logic             k;
        logic             kn;
        logic             c;
        logic             cn;
        logic             rn;
        logic             wn;
        logic [AW-1:0]    addr;
        logic [DW-1:0]    din;
        logic [SW-1:0]    sel_n;
        logic             dll_n;
        logic [REF_W-1:0] ref_code;
    } qrs_pins_type;

    typedef struct packed {
        qrs_pins_type                s1;
        qrs_pins_type                s2;
        logic [3:0]                  clk_prev;
        qrs_pkg::qrs_wr_state_type   wr_st;
        logic [DW-1:0]               wd0;
        logic [SW-1:0]               wsel0_n;
        logic [DEPTH-1:0][DW-1:0]    mem;
        logic                        rd1_v;
        logic [AW-1:0]               rd1_a;
        logic                        rd2_v;
        logic [AW-1:0]               rd2_a;
        logic                        sec_v;
        logic [AW-1:0]               sec_a;
        logic [DW-1:0]               q;
        logic                        oe;
        logic                        cq;
        logic                        cqn;
        logic [LCW-1:0]              lock_cnt;
        logic                        locked;
        logic [REF_W-1:0]            ref_q;
        logic [CCW-1:0]              cal_cnt;
        logic [REF_W-1:0]            imp;
        logic                        cal;
    } qrs_dev_state_type;

    qrs_dev_state_type r_q;
    qrs_dev_state_type r_d;
    qrs_pins_type      pins;

    logic k_rise;
    logic kn_rise;
    logic c_rise;
    logic cn_rise;
    logic out_tied;
    logic out_first;
    logic out_second;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Keeps old lanes whose select is high and takes new lanes elsewhere
    function automatic logic [DW-1:0] lane_merge(
        input logic [DW-1:0] old_word,
        input logic [DW-1:0] new_word,
        input logic [SW-1:0] sel_n
    );
        logic [DW-1:0] res;
        res = old_word;
        for (int i = 0; i < DW; i++) begin
            if (!sel_n[i / LANE]) begin
                res[i] = new_word[i];
            end
        end
        return res;
    endfunction

    function automatic logic [REF_W-1:0] imp_of(input logic [REF_W-1:0] ref_code);
        return REF_W'(ref_code / REF_W'(qrs_pkg::IMP_DIVISOR));
    endfunction

    // ------------------------------------------------------------------
    // Pin sampling and edge finding
    // ------------------------------------------------------------------
    always_comb begin
        pins          = '0;
        pins.k        = link.k;
        pins.kn       = link.k_n;
        pins.c        = link.c;
        pins.cn       = link.c_n;
        pins.rn       = link.read_n;
        pins.wn       = link.write_n;
        pins.addr     = link.addr;
        pins.din      = link.write_data_in;
        pins.sel_n    = link.byte_write_sel_n;
        pins.dll_n    = link.dll_off_n;
        pins.ref_code = impedance_ref_code;
    end

    assign k_rise     = r_q.s2.k  & ~r_q.clk_prev[3];
    assign kn_rise    = r_q.s2.kn & ~r_q.clk_prev[2];
    assign c_rise     = r_q.s2.c  & ~r_q.clk_prev[1];
    assign cn_rise    = r_q.s2.cn & ~r_q.clk_prev[0];
    // Both output clocks high means they are tied off, not running
    assign out_tied   = r_q.s2.c & r_q.s2.cn;
    assign out_first  = out_tied ? kn_rise : cn_rise;
    assign out_second = out_tied ? k_rise : c_rise;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        r_d          = r_q;
        r_d.s1       = pins;
        r_d.s2       = r_q.s1;
        r_d.clk_prev = {r_q.s2.k, r_q.s2.kn, r_q.s2.c, r_q.s2.cn};
        r_d.cal      = 1'b0;

        // Echo strobes follow whichever pair times the output data
        r_d.cq  = out_tied ? r_q.s2.k  : r_q.s2.c;
        r_d.cqn = out_tied ? r_q.s2.kn : r_q.s2.cn;

        // Read pipeline: stage one at t, stage two during t+1
        if (k_rise) begin
            r_d.rd1_v = ~r_q.s2.rn;
            if (!r_q.s2.rn) begin
                r_d.rd1_a = r_q.s2.addr;
            end
            r_d.rd2_v = r_q.rd1_v;
            r_d.rd2_a = r_q.rd1_a;
        end

        if (out_first) begin
            if (r_q.rd2_v) begin
                r_d.q     = r_q.mem[{r_q.rd2_a, 1'b0}];
                r_d.oe    = 1'b1;
                r_d.sec_v = 1'b1;
                r_d.sec_a = r_q.rd2_a;
            end else begin
                r_d.oe    = 1'b0;
                r_d.sec_v = 1'b0;
            end
        end

        // Second word ends the read burst
        if (out_second && r_q.sec_v) begin
            r_d.q     = r_q.mem[{r_q.sec_a, 1'b1}];
            r_d.sec_v = 1'b0;
        end

        // Write machine runs beside the read pipeline
        case (r_q.wr_st)
            qrs_pkg::QRS_WR_IDLE: begin
                if (k_rise && !r_q.s2.wn) begin
                    r_d.wd0     = r_q.s2.din;
                    r_d.wsel0_n = r_q.s2.sel_n;
                    r_d.wr_st   = qrs_pkg::QRS_WR_HALF;
                end
            end
            qrs_pkg::QRS_WR_HALF: begin
                if (kn_rise) begin
                    // Write address is only looked at here, so idle cycles ignore it
                    r_d.mem[{r_q.s2.addr, 1'b0}] = lane_merge(
                        r_q.mem[{r_q.s2.addr, 1'b0}], r_q.wd0, r_q.wsel0_n);
                    r_d.mem[{r_q.s2.addr, 1'b1}] = lane_merge(
                        r_q.mem[{r_q.s2.addr, 1'b1}], r_q.s2.din, r_q.s2.sel_n);
                    r_d.wr_st = qrs_pkg::QRS_WR_IDLE;
                end
            end
            default: begin
                r_d.wr_st = qrs_pkg::QRS_WR_IDLE;
            end
        endcase

        // Lock wait, then periodic impedance update
        if (k_rise && !r_q.locked) begin
            if (!r_q.s2.dll_n || r_q.lock_cnt == LCW'(qrs_pkg::LOCK_CYCLES - 1)) begin
                r_d.locked  = 1'b1;
                r_d.ref_q   = r_q.s2.ref_code;
                r_d.imp     = imp_of(r_q.s2.ref_code);
                r_d.cal     = 1'b1;
                r_d.cal_cnt = '0;
            end else begin
                r_d.lock_cnt = r_q.lock_cnt + LCW'(1);
            end
        end

        // Drift updates reuse the reference caught at lock
        if (k_rise && r_q.locked) begin
            if (r_q.cal_cnt == CCW'(qrs_pkg::CAL_CYCLES - 1)) begin
                r_d.cal_cnt = '0;
                r_d.imp     = imp_of(r_q.ref_q);
                r_d.cal     = 1'b1;
            end else begin
                r_d.cal_cnt = r_q.cal_cnt + CCW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign link.read_data_out   = r_q.q;
    assign link.read_data_oe    = r_q.oe;
    assign link.echo_strobe_pos = r_q.cq;
    assign link.echo_strobe_neg = r_q.cqn;
    assign impedance_code       = r_q.imp;
    assign impedance_cal        = r_q.cal;
    assign lock_done            = r_q.locked;
    assign dll_bypass           = ~r_q.s2.dll_n;

endmodule

//--- qrs_link_if.sv
// Purpose : Pin bundle between the memory device and its controller.
// Assumes : Read data is qualified by read_data_oe; the controller takes the first word only while it is high.
// Notes   : byte_write_sel_n carries nibble selects on the 8-bit organisation.
`timescale 1ns/1ps
interface qrs_link_if #(
    parameter int DW = qrs_pkg::DATA_WIDTH,
    parameter int AW = qrs_pkg::ADDR_WIDTH,
    parameter int SW = (DW == qrs_pkg::NARROW_WIDTH) ? 2 : DW / qrs_pkg::LANE_WIDE
);
    logic          k;
    logic          k_n;
    logic          c;
    logic          c_n;
    logic          read_n;
    logic          write_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] write_data_in;
    logic [SW-1:0] byte_write_sel_n;
    logic          dll_off_n;
    logic [DW-1:0] read_data_out;
    logic          read_data_oe;
    logic          echo_strobe_pos;
    logic          echo_strobe_neg;

    modport dev (
        input  k, k_n, c, c_n, read_n, write_n, addr, write_data_in,
               byte_write_sel_n, dll_off_n,
        output read_data_out, read_data_oe, echo_strobe_pos, echo_strobe_neg
    );

    modport ctl (
        output k, k_n, c, c_n, read_n, write_n, addr, write_data_in,
               byte_write_sel_n, dll_off_n,
        input  read_data_out, read_data_oe, echo_strobe_pos, echo_strobe_neg
    );
endinterface

//--- qrs_link_props.sv
// Purpose : Timing checks on the pins between controller and device.
// Assumes : K half period of 4 clks, output clocks in use or tied high.
// Notes   : Repetition counts are written for that half period.
`timescale 1ns/1ps
module qrs_link_props (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic k,
    input wire logic k_n,
    input wire logic c,
    input wire logic c_n,
    input wire logic read_n,
    input wire logic read_data_oe,
    input wire logic echo_strobe_pos,
    input wire logic echo_strobe_neg
);
    logic [5:0] since_rd_q;
    logic [5:0] quiet_q;
    logic       pos_q;
    // Counters instead of long repetitions keep the checks cheap
    always_ff @(posedge clk) begin
        pos_q <= echo_strobe_pos;
        if (!rst_b || echo_strobe_pos != pos_q) begin
            quiet_q <= 6'h00;
        end else begin
            quiet_q <= quiet_q + 6'h01;
        end
        if (!rst_b) begin
            since_rd_q <= 6'h3f;
        end else if (!read_n) begin
            since_rd_q <= 6'h00;
        end else if (since_rd_q != 6'h3f) begin
            since_rd_q <= since_rd_q + 6'h01;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_k_high;
        k[*4];
    endsequence
    sequence s_k_low;
        (!k)[*4];
    endsequence
    sequence s_word_out;
        $rose(read_data_oe);
    endsequence
    a_k_period: assert property ($rose(k) |-> s_k_high ##1 s_k_low ##1 k)
        else $error("input clock period wrong");
    a_k_compl: assert property ($rose(k) || $rose(k_n) |-> k != k_n)
        else $error("input clock pair not complementary");
    a_out_clk_src: assert property ((c && c_n) || (c == k && c_n == k_n))
        else $error("output clock neither tied nor following input clock");
    a_oe_from_read: assert property ($rose(read_data_oe) |-> since_rd_q < 6'h18)
        else $error("read bus driven without a read");
    a_oe_two_words: assert property (s_word_out |-> read_data_oe[*8])
        else $error("read burst shorter than two words");
    a_word0_echo: assert property (s_word_out |-> $rose(echo_strobe_neg))
        else $error("first word not on complement edge");
    a_read_latency: assert property ($fell(read_n) |-> ##[10:24] s_word_out)
        else $error("read data late or missing");
    a_echo_runs: assert property (quiet_q < 6'h0c)
        else $error("echo strobe stopped");
endmodule

//--- qrs_pkg.sv
// Purpose : Shared constants and types of the two-word burst static RAM link.
// Assumes : Both ends run on one 100 MHz system clock; link pins are sampled.
// Notes   : Counts of link-clock periods are in K cycles, not system cycles.
package qrs_pkg;

    // ------------------------------------------------------------------
    // Organisation
    // ------------------------------------------------------------------
    localparam int DATA_WIDTH    = 18;
    localparam int ADDR_WIDTH    = 4;
    localparam int LANE_NARROW   = 4;
    localparam int LANE_WIDE     = 9;
    localparam int NARROW_WIDTH  = 8;
    localparam int REF_WIDTH     = 8;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int K_HALF_CYCLES = 4;
    localparam int LOCK_CYCLES   = 1024;
    localparam int CAL_CYCLES    = 1024;
    localparam int IMP_DIVISOR   = 5;
    localparam int FIFO_DEPTH    = 8;

    // ------------------------------------------------------------------
    // Write burst states
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        QRS_WR_IDLE = 1'h0,
        QRS_WR_HALF = 1'h1
    } qrs_wr_state_type;

endpackage

//--- testbench.sv
// Purpose : Self-checking bench joining controller and device across the link.
// Assumes : Default organisation; lock bypassed so the output stage runs at once.
// Notes   : Inputs move on falling edges and results are sampled there.
`timescale 1ns/1ps
module testbench;
    localparam int          DW = qrs_pkg::DATA_WIDTH;
    localparam logic [17:0] A0 = 18'h1_1111;
    localparam logic [17:0] A1 = 18'h2_2222;
    localparam logic [17:0] B0 = 18'h3_3333;
    localparam logic [17:0] B1 = 18'h0_4444;
    localparam logic [17:0] LO = 18'h0_01ff;
    logic          clk;
    logic          rst_b;
    logic          wr_valid, wr_ready, rd_valid, rd_ready, rd_done;
    logic          lock_done, dll_bypass, imp_cal;
    logic [3:0]    wr_addr, rd_addr;
    logic [1:0]    sel0_n, sel1_n;
    logic [DW-1:0] wd0, wd1, rd0, rd1, q0, q1;
    logic [7:0]    imp_code;
    int            mismatches = 0;
    int            n_tests = 0;
    int            cycles = 0;
    int            stalls = 0;
    int            cal_seen = 0;
    qrs_link_if i_qrs_link_if ();
    qrs_device i_qrs_device (.clk(clk), .rst_b(rst_b), .link(i_qrs_link_if.dev),
        .impedance_ref_code(8'h64), .impedance_code(imp_code), .impedance_cal(imp_cal),
        .lock_done(lock_done), .dll_bypass(dll_bypass));
    qrs_controller i_qrs_controller (.clk(clk), .rst_b(rst_b), .link(i_qrs_link_if.ctl),
        .dll_enable(1'b0), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
        .wr_data0(wd0), .wr_data1(wd1), .wr_sel0_n(sel0_n), .wr_sel1_n(sel1_n),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_addr(rd_addr), .rd_done(rd_done),
        .rd_data0(rd0), .rd_data1(rd1));
    qrs_link_props i_qrs_link_props (.clk(clk), .rst_b(rst_b), .k(i_qrs_link_if.k),
        .k_n(i_qrs_link_if.k_n), .c(i_qrs_link_if.c), .c_n(i_qrs_link_if.c_n),
        .read_n(i_qrs_link_if.read_n), .read_data_oe(i_qrs_link_if.read_data_oe),
        .echo_strobe_pos(i_qrs_link_if.echo_strobe_pos),
        .echo_strobe_neg(i_qrs_link_if.echo_strobe_neg));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic end_sim();
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // A hung handshake must still reach the closing report
    always @(posedge clk) begin
        cycles++;
        if (imp_cal === 1'b1) begin
            cal_seen++;
        end
        if (cycles == 5000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Leaves wr_valid high so back-to-back pushes need no idle cycle
    task automatic wr(input logic [3:0] a, input logic [DW-1:0] d0, input logic [DW-1:0] d1,
                      input logic [1:0] s0, input logic [1:0] s1);
        wr_addr = a;
        wd0 = d0;
        wd1 = d1;
        sel0_n = s0;
        sel1_n = s1;
        wr_valid = 1'b1;
        while (wr_ready !== 1'b1) begin
            stalls++;
            @(negedge clk);
        end
        @(negedge clk);
    endtask
    task automatic rd(input logic [3:0] a);
        int n;
        rd_addr = a;
        rd_valid = 1'b1;
        while (rd_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        rd_valid = 1'b0;
        n = 0;
        while (rd_done !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        chk("rd_done", 32'(rd_done), 32'h0000_0001);
        q0 = rd0;
        q1 = rd1;
    endtask
    task automatic t_basic();
        wr(4'h3, A0, A1, 2'h0, 2'h0);
        wr_valid = 1'b0;
        rd(4'h3);
        chk("word0", 32'(q0), 32'(A0));
        chk("word1", 32'(q1), 32'(A1));
        rd(4'h2);
        chk("neighbour", 32'({q0, q1}), 32'h0000_0000);
    endtask
    task automatic t_lanes();
        wr(4'h3, B0, B1, 2'h2, 2'h1);
        wr_valid = 1'b0;
        rd(4'h3);
        chk("lane word0", 32'(q0), 32'((A0 & ~LO) | (B0 & LO)));
        chk("lane word1", 32'(q1), 32'((B1 & ~LO) | (A1 & LO)));
    endtask
    // Write is queued just after a slot so it issues with the read
    task automatic t_both();
        while (rd_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        wr(4'h7, B1, B0, 2'h0, 2'h0);
        wr_valid = 1'b0;
        rd(4'h3);
        chk("read beside write", 32'(q1), 32'((B1 & ~LO) | (A1 & LO)));
        rd(4'h7);
        chk("write beside read", 32'({q0[8:0], q1[8:0]}), 32'({B1[8:0], B0[8:0]}));
    endtask
    task automatic t_fill();
        stalls = 0;
        for (int i = 0; i < 10; i++) begin
            wr(4'(i + 4), 18'(i * 3), 18'(i * 5), 2'h0, 2'h0);
        end
        wr_valid = 1'b0;
        chk("queue refused", 32'(stalls != 0), 32'h0000_0001);
        // A full queue drains one burst per K period; let it empty first
        repeat (9 * 2 * qrs_pkg::K_HALF_CYCLES) @(negedge clk);
        rd(4'hd);
        chk("last queued", 32'({q0[8:0], q1[8:0]}), 32'h0000_362d);
    endtask
    initial begin
        rst_b = 1'b0;
        wr_valid = 1'b0;
        rd_valid = 1'b0;
        wr_addr = 4'h0;
        rd_addr = 4'h0;
        wd0 = '0;
        wd1 = '0;
        sel0_n = 2'h3;
        sel1_n = 2'h3;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        t_basic();
        t_lanes();
        t_both();
        t_fill();
        chk("bypass", 32'({lock_done, dll_bypass}), 32'h0000_0003);
        chk("impedance", 32'(imp_code), 32'h0000_0014);
        chk("cal pulses", 32'(cal_seen), 32'h0000_0001);
        end_sim();
    end
endmodule
